// ==== rtl/uart_link.sv ====
/*
 * package of shared constants, plus the 8N1 serial transmitter/receiver
 * assumes one clock (ref_clk, 125 MHz), synchronous active-low reset,
 * and an rxd pin from outside the clock domain
 */
package cmd_port_pkg;
    localparam int          CLK_HZ    = 125_000_000;
    localparam int          BAUD_RATE = 19200;
    localparam int          BAUD_DIV  = CLK_HZ / BAUD_RATE;
    localparam int          DATA_BITS = 8;
    localparam int          STOP_LEN  = 5;
    localparam int          FRAC_BITS = 12;
    localparam logic [15:0] COUNT_MAX = 16'h3FFC;
    localparam logic [15:0] AVE_RST   = 16'h0001;
    localparam logic [15:0] PKT_RST   = 16'h0000;
    localparam logic [19:0] ARG_MAX   = 20'h0_FFFF;
    localparam logic [7:0]  CH_BANG   = 8'h21;
    localparam logic [7:0]  CH_DOLLAR = 8'h24;
    localparam logic [7:0]  CH_CR     = 8'h0D;
    localparam logic [7:0]  CH_TAB    = 8'h09;
    localparam logic [7:0]  CH_DOT    = 8'h2E;
    localparam logic [7:0]  CH_ZERO   = 8'h30;
    localparam logic [7:0]  CH_NINE   = 8'h39;
    localparam logic [7:0]  CH_SPACE  = 8'h20;
    localparam logic [23:0] CMD_AVE   = 24'h61_7665;
    localparam logic [23:0] CMD_PKT   = 24'h70_6B74;
    localparam logic [23:0] CMD_RLS   = 24'h72_6C73;
    localparam logic [23:0] CMD_RUN   = 24'h72_756E;
    localparam logic [23:0] CMD_STO   = 24'h73_746F;
    typedef enum logic [1:0] {PS_IDLE = 2'b00, PS_NAME = 2'b01, PS_ARG = 2'b11} parse_e;
endpackage

`timescale 1ns/1ps
module uart_link
    import cmd_port_pkg::*;
#(
    parameter int BAUD_DIV_P = BAUD_DIV
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       rxd,
    output logic            txd_q,
    output logic            rx_valid_q,
    output logic [7:0]      rx_byte_q,
    input  wire logic       tx_start,
    input  wire logic [7:0] tx_byte,
    output logic            tx_busy_q
);
    if (BAUD_DIV_P < 4 || BAUD_DIV_P > 65535) begin : g_chk
        $error("uart_link: BAUD_DIV_P out of range");
    end

    localparam logic [15:0] DIV_M1  = 16'(BAUD_DIV_P - 1);
    localparam logic [15:0] DIV_HALF = 16'(BAUD_DIV_P / 2);

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    logic        sync1_q, sync2_q;
    logic        rx_busy_q;
    logic [15:0] rcnt_q;
    logic [3:0]  rbit_q;
    logic [7:0]  rsh_q;
    wire         rtick = rx_busy_q && rcnt_q == 16'h0000;

    always_ff @(posedge ref_clk) begin
        sync1_q <= rst_b ? rxd : 1'b1;
        sync2_q <= rst_b ? sync1_q : 1'b1;
    end

    // sampling at mid-bit gives half a bit of margin on either side
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rx_busy_q  <= 1'b0;
            rcnt_q     <= 16'h0000;
            rbit_q     <= 4'h0;
            rsh_q      <= 8'h00;
            rx_valid_q <= 1'b0;
            rx_byte_q  <= 8'h00;
        end else begin
            rx_valid_q <= 1'b0;
            if (!rx_busy_q) begin
                if (!sync2_q) begin
                    rx_busy_q <= 1'b1;
                    rcnt_q    <= DIV_HALF;
                    rbit_q    <= 4'h0;
                end
            end else if (!rtick) begin
                rcnt_q <= rcnt_q - 16'h0001;
            end else begin
                rcnt_q <= DIV_M1;
                rbit_q <= rbit_q + 4'h1;
                if (rbit_q == 4'h0 && sync2_q) begin
                    rx_busy_q <= 1'b0;
                end else if (rbit_q == 4'(DATA_BITS + 1)) begin
                    rx_busy_q  <= 1'b0;
                    rx_valid_q <= sync2_q;
                    rx_byte_q  <= rsh_q;
                end else if (rbit_q != 4'h0) begin
                    rsh_q <= {sync2_q, rsh_q[7:1]};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    logic [15:0] tcnt_q;
    logic [3:0]  tbit_q;
    logic [8:0]  tsh_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tx_busy_q <= 1'b0;
            txd_q     <= 1'b1;
            tcnt_q    <= 16'h0000;
            tbit_q    <= 4'h0;
            tsh_q     <= 9'h1FF;
        end else if (!tx_busy_q) begin
            if (tx_start) begin
                tx_busy_q <= 1'b1;
                txd_q     <= 1'b0;
                tsh_q     <= {1'b1, tx_byte};
                tcnt_q    <= DIV_M1;
                tbit_q    <= 4'h0;
            end
        end else if (tcnt_q != 16'h0000) begin
            tcnt_q <= tcnt_q - 16'h0001;
        end else begin
            tcnt_q <= DIV_M1;
            tbit_q <= tbit_q + 4'h1;
            txd_q  <= tsh_q[0];
            tsh_q  <= {1'b1, tsh_q[8:1]};
            if (tbit_q == 4'(DATA_BITS + 1)) begin
                tx_busy_q <= 1'b0;
                txd_q     <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_start_bit;
        @(posedge ref_clk) disable iff (!rst_b)
        tx_start && !tx_busy_q |=> !txd_q [*8];
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("start bit not held low");
endmodule

// ==== rtl/sensor_serial_command_port.sv ====
/*
 * serial command interpreter and record formatter of the sensor
 * assumes measurement inputs, coefficients and flash handshake come from
 * logic on ref_clk; only rxd is asynchronous
 */
// What this block does
// - link runs 19200 baud, 8N1, no flow
// - reported counts clamped to 0..16380
// - record: id, ref, sig, corrected, beam, thermistor
// - five bangs stop collection, enter setup
// - ave argument 1..65535 sets averaging count
// - pkt argument 0..65535 sets packet length
// - rls reloads working settings from flash
// - run leaves setup, resumes output
// - sto writes working settings to flash
// - corrected = sig * (slope*ref/base + offset)
// - step settles within two output records
`timescale 1ns/1ps
module sensor_serial_command_port
    import cmd_port_pkg::*;
#(
    parameter int               BAUD_DIV_P = BAUD_DIV,
    parameter logic [63:0]      UNIT_ID    = 64'h554E_4954_2D30_3031  // arbitrary value
) (
    input  wire logic               ref_clk,
    input  wire logic               rst_b,
    input  wire logic               rxd,
    output logic                    txd_q,
    input  wire logic               meas_valid,
    input  wire logic [15:0]        meas_ref,
    input  wire logic [15:0]        meas_sig,
    input  wire logic [15:0]        meas_therm,
    input  wire logic [15:0]        beam_c_milli,
    input  wire logic signed [15:0] coef_slope,
    input  wire logic signed [15:0] coef_offset,
    input  wire logic [15:0]        base_recip,
    input  wire logic               nv_load_done,
    input  wire logic [15:0]        nv_ave,
    input  wire logic [15:0]        nv_pkt,
    output logic                    setup_q,
    output logic                    nv_store_q,
    output logic                    nv_load_q,
    output logic [15:0]             ave_len_q,
    output logic [15:0]             pkt_len_q
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [15:0] clamp_cnt(input logic [31:0] x);
        return (x > 32'(COUNT_MAX)) ? COUNT_MAX : x[15:0];
    endfunction

    function automatic logic [15:0] corr_of(input logic [15:0] r, input logic [15:0] s,
                                           input logic signed [15:0] slope,
                                           input logic signed [15:0] off,
                                           input logic [15:0] recip);
        logic signed [63:0] ratio;
        logic signed [63:0] g;
        logic signed [63:0] p;
        ratio = $signed({32'h0000_0000, ({16'h0000, r} * {16'h0000, recip}) >> 16});
        g = ((64'(slope) * ratio) >>> FRAC_BITS) + 64'(off);
        p = (g * $signed({48'h0000_0000_0000, s})) >>> FRAC_BITS;
        if (p < 0) return 16'h0000;
        return clamp_cnt((p > 64'(COUNT_MAX)) ? 32'(COUNT_MAX) : p[31:0]);
    endfunction

    function automatic logic [3:0] dec_digit(input logic [15:0] v, input logic [2:0] k);
        logic [15:0] pw;
        unique case (k)
            3'd0:    pw = 16'h0001;
            3'd1:    pw = 16'h000A;
            3'd2:    pw = 16'h0064;
            3'd3:    pw = 16'h03E8;
            default: pw = 16'h2710;
        endcase
        return 4'((v / pw) % 16'h000A);
    endfunction

    // ------------------------------------------------------------
    // serial link
    // ------------------------------------------------------------
    logic       rx_valid, tx_busy;
    logic [7:0] rx_byte;
    logic       tx_start_q;
    logic [7:0] tx_byte_q;

    uart_link #(.BAUD_DIV_P(BAUD_DIV_P)) u_link (
        .ref_clk    (ref_clk),
        .rst_b      (rst_b),
        .rxd        (rxd),
        .txd_q      (txd_q),
        .rx_valid_q (rx_valid),
        .rx_byte_q  (rx_byte),
        .tx_start   (tx_start_q),
        .tx_byte    (tx_byte_q),
        .tx_busy_q  (tx_busy)
    );

    // ------------------------------------------------------------
    // command parser
    // ------------------------------------------------------------
    parse_e      ps_q;
    logic [2:0]  bang_q;
    logic [23:0] name_q;
    logic [1:0]  nlen_q;
    logic [19:0] arg_q;
    logic        have_q, bad_q;

    wire         is_digit = rx_byte >= CH_ZERO && rx_byte <= CH_NINE;
    wire  [19:0] arg_nx   = 20'(arg_q * 20'd10) + 20'(rx_byte - CH_ZERO);
    wire         cmd_go   = setup_q && rx_valid && ps_q == PS_ARG && rx_byte == CH_CR && !bad_q;
    wire         go_ave   = cmd_go && name_q == CMD_AVE && have_q && arg_q != 20'h0_0000;
    wire         go_pkt   = cmd_go && name_q == CMD_PKT && have_q;
    wire         go_rls   = cmd_go && name_q == CMD_RLS && !have_q;
    wire         go_run   = cmd_go && name_q == CMD_RUN && !have_q;
    wire         go_sto   = cmd_go && name_q == CMD_STO && !have_q;
    wire         stop_hit = !setup_q && rx_valid && rx_byte == CH_BANG && bang_q == 3'(STOP_LEN - 1);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            bang_q <= 3'h0;
        end else if (rx_valid && !setup_q) begin
            bang_q <= (rx_byte == CH_BANG && !stop_hit) ? bang_q + 3'h1 : 3'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ps_q   <= PS_IDLE;
            name_q <= 24'h00_0000;
            nlen_q <= 2'h0;
            arg_q  <= 20'h0_0000;
            have_q <= 1'b0;
            bad_q  <= 1'b0;
        end else if (!setup_q) begin
            ps_q <= PS_IDLE;
        end else if (rx_valid) begin
            unique case (ps_q)
                PS_IDLE: begin
                    nlen_q <= 2'h0;
                    if (rx_byte == CH_DOLLAR) ps_q <= PS_NAME;
                end
                PS_NAME: begin
                    name_q <= {name_q[15:0], rx_byte};
                    nlen_q <= nlen_q + 2'h1;
                    if (rx_byte == CH_CR) ps_q <= PS_IDLE;
                    else if (nlen_q == 2'h2) begin
                        ps_q   <= PS_ARG;
                        arg_q  <= 20'h0_0000;
                        have_q <= 1'b0;
                        bad_q  <= 1'b0;
                    end
                end
                PS_ARG: begin
                    // out-of-range numbers poison the line, command is dropped
                    if (rx_byte == CH_CR) ps_q <= PS_IDLE;
                    else if (is_digit) begin
                        arg_q  <= arg_nx;
                        have_q <= 1'b1;
                        if (arg_nx > ARG_MAX) bad_q <= 1'b1;
                    end else if (rx_byte != CH_SPACE) bad_q <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) setup_q <= 1'b0;
        else if (stop_hit) setup_q <= 1'b1;
        else if (go_run) setup_q <= 1'b0;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ave_len_q <= AVE_RST;
            pkt_len_q <= PKT_RST;
        end else if (nv_load_done) begin
            ave_len_q <= (nv_ave == 16'h0000) ? AVE_RST : nv_ave;
            pkt_len_q <= nv_pkt;
        end else begin
            if (go_ave) ave_len_q <= arg_q[15:0];
            if (go_pkt) pkt_len_q <= arg_q[15:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        nv_store_q <= rst_b && go_sto;
        nv_load_q  <= rst_b && go_rls;
    end

    // ------------------------------------------------------------
    // averaging
    // ------------------------------------------------------------
    logic [31:0] acc_q [1:5];
    logic [15:0] rec_q [1:5];
    logic [15:0] n_q, pcnt_q;
    logic        emit_q, pend_q;
    logic [15:0] now_v [1:5];
    logic [31:0] sum_v [1:5];

    assign now_v[1] = meas_ref;
    assign now_v[2] = meas_sig;
    assign now_v[3] = corr_of(meas_ref, meas_sig, coef_slope, coef_offset, base_recip);
    assign now_v[4] = beam_c_milli;
    assign now_v[5] = meas_therm;
    for (genvar i = 1; i <= 5; i++) begin : g_sum
        assign sum_v[i] = acc_q[i] + {16'h0000, now_v[i]};
    end

    wire take   = meas_valid && !setup_q;
    wire blk_ok = take && n_q + 16'h0001 >= ave_len_q;
    wire latch  = blk_ok && !emit_q;
    wire pk_end = pkt_len_q != 16'h0000 && pcnt_q + 16'h0001 == pkt_len_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_b || setup_q || blk_ok) begin
            n_q <= 16'h0000;
            for (int i = 1; i <= 5; i++) acc_q[i] <= 32'h0000_0000;
        end else if (take) begin
            n_q <= n_q + 16'h0001;
            for (int i = 1; i <= 5; i++) acc_q[i] <= sum_v[i];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            for (int i = 1; i <= 5; i++) rec_q[i] <= 16'h0000;
        end else if (latch) begin
            for (int i = 1; i <= 5; i++) begin
                rec_q[i] <= (i == 4) ? 16'(sum_v[i] / {16'h0000, ave_len_q})
                                     : clamp_cnt(sum_v[i] / {16'h0000, ave_len_q});
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b || pkt_len_q == 16'h0000) begin
            pcnt_q <= 16'h0000;
            pend_q <= 1'b0;
        end else if (latch) begin
            pcnt_q <= pk_end ? 16'h0000 : pcnt_q + 16'h0001;
            pend_q <= pk_end;
        end
    end

    // ------------------------------------------------------------
    // record formatter
    // ------------------------------------------------------------
    logic [2:0] fld_q, dig_q;
    logic       lead_q;

    wire        beam    = fld_q == 3'd4;
    wire  [2:0] k       = (beam && dig_q > 3'd2) ? 3'd6 - dig_q : 3'd5 - dig_q;
    wire  [3:0] d       = dec_digit(rec_q[fld_q == 3'd0 ? 1 : (fld_q > 3'd5 ? 5 : fld_q)], k);
    wire        is_dot  = beam && dig_q == 3'd3;
    wire        num_dig = fld_q != 3'd0 && fld_q != 3'd6 && dig_q != 3'd0 && !is_dot;
    wire        can_snd = !tx_busy && !tx_start_q;
    logic [7:0] byte_v;
    logic       skip_v, last_v;

    always_comb begin
        byte_v = CH_ZERO + {4'h0, d};
        skip_v = num_dig && !lead_q && d == 4'h0 && k > (beam ? 3'd3 : 3'd0);
        last_v = dig_q == (beam ? 3'd6 : 3'd5);
        if (fld_q == 3'd0) begin
            byte_v = UNIT_ID[8 * (7 - dig_q) +: 8];
            last_v = dig_q == 3'd7;
        end else if (fld_q == 3'd6) begin
            byte_v = CH_CR;
            skip_v = dig_q != 3'd0 && !pend_q;
            last_v = dig_q == 3'd1;
        end else if (dig_q == 3'd0) begin
            byte_v = CH_TAB;
        end else if (is_dot) begin
            byte_v = CH_DOT;
        end
    end

    wire step = emit_q && (skip_v || can_snd);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            emit_q <= 1'b0;
            fld_q  <= 3'd0;
            dig_q  <= 3'd0;
            lead_q <= 1'b0;
        end else if (latch) begin
            emit_q <= 1'b1;
            fld_q  <= 3'd0;
            dig_q  <= 3'd0;
            lead_q <= 1'b0;
        end else if (step) begin
            dig_q  <= last_v ? 3'd0 : dig_q + 3'd1;
            lead_q <= !last_v && (lead_q || (num_dig && !skip_v));
            if (last_v) fld_q <= fld_q + 3'd1;
            if (last_v && fld_q == 3'd6) emit_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        tx_start_q <= rst_b && emit_q && !skip_v && can_snd;
        tx_byte_q  <= rst_b ? byte_v : 8'h00;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    property p_range;
        emit_q |-> rec_q[1] <= COUNT_MAX && rec_q[2] <= COUNT_MAX && rec_q[3] <= COUNT_MAX && rec_q[5] <= COUNT_MAX;
    endproperty
    a_range: assert property (p_range) else $error("count out of range");
    property p_id_first;
        emit_q && fld_q == 3'd0 && dig_q == 3'd0 && can_snd |=> tx_start_q && tx_byte_q == UNIT_ID[63:56];
    endproperty
    a_id_first: assert property (p_id_first) else $error("record does not open with id");
    property p_stop;
        stop_hit |=> setup_q;
    endproperty
    a_stop: assert property (p_stop) else $error("stop sequence ignored");
    property p_ave;
        go_ave && !nv_load_done |=> ave_len_q == $past(arg_q[15:0]) && ave_len_q != 16'h0000;
    endproperty
    a_ave: assert property (p_ave) else $error("ave not taken");
    property p_pkt;
        go_pkt && !nv_load_done |=> pkt_len_q == $past(arg_q[15:0]);
    endproperty
    a_pkt: assert property (p_pkt) else $error("pkt not taken");
    property p_rls;
        go_rls |=> nv_load_q ##1 !nv_load_q;
    endproperty
    a_rls: assert property (p_rls) else $error("reload not requested");
    property p_run;
        go_run |=> !setup_q;
    endproperty
    a_run: assert property (p_run) else $error("run did not leave setup");
    property p_sto;
        go_sto |=> nv_store_q ##1 !nv_store_q;
    endproperty
    a_sto: assert property (p_sto) else $error("store not one pulse");
    property p_cr;
        emit_q && fld_q == 3'd6 && dig_q == 3'd0 && can_snd |=> tx_start_q && tx_byte_q == CH_CR;
    endproperty
    a_cr: assert property (p_cr) else $error("record not ended by CR");
    property p_settle;
        blk_ok |=> n_q == 16'h0000;
    endproperty
    a_settle: assert property (p_settle) else $error("block average not restarted");

    c_stop:   cover property (stop_hit);
    c_record: cover property (emit_q ##1 !emit_q);
    c_store:  cover property (go_sto);
    c_pkt:    cover property (latch && pk_end);
endmodule

// ==== tb/host_term.sv ====
/*
 * host terminal model: sends 8N1 frames on rxd, decodes txd_q frames
 * into rx_q; assumes send_str is called just after a rising edge
 */
`timescale 1ns/1ps
module host_term #(
    parameter int DIV = 8
) (
    input  wire logic ref_clk,
    output logic      rxd,
    input  wire logic txd_q
);
    logic [7:0] rx_q[$];
    logic [7:0] rx_b;
    logic [9:0] fr;
    int         i;
    int         j;
    int         k;
    // --------------------------------
    // sender
    // --------------------------------
    initial rxd = 1'b1;
    task automatic send_byte(input logic [7:0] b);
        fr = {1'b1, b, 1'b0};
        for (i = 0; i < 10; i++) begin
            rxd <= fr[i];
            repeat (DIV) @(posedge ref_clk);
        end
    endtask
    task automatic send_str(input string s);
        for (j = 0; j < s.len(); j++) begin
            send_byte(s[j]);
        end
    endtask
    // --------------------------------
    // receiver
    // --------------------------------
    // mid-bit sampling, bad stop dropped
    always begin
        @(negedge txd_q);
        repeat (DIV / 2) @(posedge ref_clk);
        for (k = 0; k < 8; k++) begin
            repeat (DIV) @(posedge ref_clk);
            rx_b[k] = txd_q;
        end
        repeat (DIV) @(posedge ref_clk);
        if (txd_q === 1'b1) begin
            rx_q.push_back(rx_b);
        end
    end
endmodule

// ==== tb/tb_top.sv ====
/*
 * self-checking bench of the command port: records, stop sequence,
 * setting commands, flash handshake; assumes host_term on the serial side
 */
`timescale 1ns/1ps
module tb_top
    import cmd_port_pkg::*;
;
    localparam int DIV = 8;
    logic        ref_clk;
    logic        rst_b;
    logic        rxd;
    logic        txd_q;
    logic        meas_valid;
    logic [15:0] meas_ref;
    logic [15:0] meas_sig;
    logic [15:0] meas_therm;
    logic [15:0] beam_c_milli;
    logic        nv_load_done;
    logic [15:0] nv_ave;
    logic [15:0] nv_pkt;
    logic        setup_q;
    logic        nv_store_q;
    logic        nv_load_q;
    logic [15:0] ave_len_q;
    logic [15:0] pkt_len_q;
    int          fail_count;
    int          checks_done;
    int          sto_n;
    int          rls_n;
    int          w;
    // --------------------------------
    // design and host
    // --------------------------------
    // unit id value is arbitrary
    sensor_serial_command_port #(.BAUD_DIV_P(DIV), .UNIT_ID(64'h5445_5354_2D30_3037)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .rxd(rxd), .txd_q(txd_q), .meas_valid(meas_valid),
        .meas_ref(meas_ref), .meas_sig(meas_sig), .meas_therm(meas_therm), .beam_c_milli(beam_c_milli),
        // ratio 0.5, gain 0.75: slope and offset both matter
        .coef_slope(16'sh0800), .coef_offset(16'sh0800), .base_recip(16'h4000),
        .nv_load_done(nv_load_done), .nv_ave(nv_ave), .nv_pkt(nv_pkt), .setup_q(setup_q),
        .nv_store_q(nv_store_q), .nv_load_q(nv_load_q), .ave_len_q(ave_len_q), .pkt_len_q(pkt_len_q));
    host_term #(.DIV(DIV)) u_host (.ref_clk(ref_clk), .rxd(rxd), .txd_q(txd_q));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // one-cycle pulses counted, never missed
    always @(posedge ref_clk) begin
        if (nv_store_q === 1'b1) sto_n++;
        if (nv_load_q === 1'b1) rls_n++;
    end
    // --------------------------------
    // shared tasks
    // --------------------------------
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cmd(input string s);
        u_host.send_str(s);
        repeat (20) @(posedge ref_clk);
    endtask
    task automatic meas(input logic [15:0] r, input logic [15:0] s, input logic [15:0] t, input logic [15:0] b);
        meas_valid <= 1'b1;
        meas_ref <= r;
        meas_sig <= s;
        meas_therm <= t;
        beam_c_milli <= b;
        @(posedge ref_clk);
        meas_valid <= 1'b0;
        @(posedge ref_clk);
    endtask
    // whole record compared byte by byte, queue left empty
    task automatic rec(input string s);
        for (w = 0; w < 20000 && u_host.rx_q.size() < s.len(); w++) @(posedge ref_clk);
        for (w = 0; w < s.len(); w++) begin
            check("record byte", (u_host.rx_q.size() > 0) ? u_host.rx_q.pop_front() : 8'h00, s[w]);
        end
        repeat (400) @(posedge ref_clk);
        check("spare bytes", u_host.rx_q.size(), 0);
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_reset();
        check("setup", setup_q, 1'b0);
        check("ave", ave_len_q, AVE_RST);
        check("pkt", pkt_len_q, PKT_RST);
        check("txd", txd_q, 1'b1);
    endtask
    task automatic t_record();
        meas(16'h2000, 16'h4E20, 16'h020F, 16'h0003);
        rec("TEST-007\t8192\t16380\t15000\t0.003\t527\r");
    endtask
    task automatic t_stop();
        cmd("!!!!x");
        check("setup", setup_q, 1'b0);
        cmd("!!!!!");
        check("setup", setup_q, 1'b1);
        meas(16'h2000, 16'h0064, 16'h020F, 16'h0003);
        rec("");
    endtask
    task automatic t_args();
        cmd("$ave 4\r");
        check("ave", ave_len_q, 16'h0004);
        cmd("$ave 0\r");
        check("ave", ave_len_q, 16'h0004);
        cmd("$pkt 65535\r");
        check("pkt", pkt_len_q, 16'hFFFF);
        cmd("$pkt 65536\r");
        check("pkt", pkt_len_q, 16'hFFFF);
    endtask
    task automatic t_flash();
        cmd("$sto\r");
        check("store pulses", sto_n, 1);
        cmd("$rls\r");
        check("load pulses", rls_n, 1);
        nv_ave <= 16'h0002;
        nv_pkt <= 16'h0003;
        nv_load_done <= 1'b1;
        @(posedge ref_clk);
        nv_load_done <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("ave", ave_len_q, 16'h0002);
        check("pkt", pkt_len_q, 16'h0003);
    endtask
    task automatic t_run();
        cmd("$pkt 1\r");
        cmd("$run\r");
        check("setup", setup_q, 1'b0);
        meas(16'h2000, 16'h0064, 16'h020F, 16'h0003);
        meas(16'h2000, 16'h012D, 16'h0210, 16'h0005);
        rec("TEST-007\t8192\t200\t150\t0.004\t527\r\r");
    endtask
    // --------------------------------
    // main sequence and watchdog
    // --------------------------------
    initial begin
        fail_count = 0;
        checks_done = 0;
        sto_n = 0;
        rls_n = 0;
        rst_b = 1'b0;
        meas_valid = 1'b0;
        meas_ref = 16'h0000;
        meas_sig = 16'h0000;
        meas_therm = 16'h0000;
        beam_c_milli = 16'h0000;
        nv_load_done = 1'b0;
        nv_ave = 16'h0000;
        nv_pkt = 16'h0000;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_reset();
        t_record();
        t_stop();
        t_args();
        t_flash();
        t_run();
        end_of_test();
    end
    // run needs about 12500 cycles
    initial begin
        repeat (50000) @(posedge ref_clk);
        fail_count++;
        end_of_test();
    end
endmodule
